// File: rtl/afb_pkg.sv
/*
 * Constants shared by the serial API frame builder: frame bytes, field offsets,
 * length figures, status encodings and the register map of the control port.
 * Assumes a byte-wide output stream towards a host parser and a 32-bit bus.
 */
package afb_pkg;

  // ************************************************************************
  // Frame layout
  // ************************************************************************
  localparam logic [7:0] DELIM = 8'h7E;
  localparam logic [7:0] TYPE_RESP = 8'h88;
  localparam logic [7:0] TYPE_MODEM = 8'h8A;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam logic [4:0] OFF_LEN_HI = 5'h01;
  localparam logic [4:0] OFF_LEN_LO = 5'h02;
  localparam logic [4:0] OFF_TYPE = 5'h03;
  localparam logic [4:0] OFF_ID = 5'h04;
  localparam logic [4:0] OFF_CHAR0 = 5'h05;
  localparam logic [4:0] OFF_CHAR1 = 5'h06;
  localparam logic [4:0] OFF_STATUS = 5'h07;
  localparam logic [4:0] OFF_DATA = 5'h08;
  localparam logic [7:0] RESP_BASE_LEN = 8'h05;
  localparam logic [7:0] MODEM_LEN = 8'h02;
  localparam logic [7:0] NO_ID = 8'h00;

  // ************************************************************************
  // Command outcome and modem event codes
  // ************************************************************************
  localparam logic [7:0] CMD_OK = 8'h00;
  localparam logic [7:0] CMD_ERROR = 8'h01;
  localparam logic [7:0] CMD_UNKNOWN = 8'h02;
  localparam logic [7:0] CMD_BAD_PARAM = 8'h03;
  localparam logic [7:0] CMD_TX_FAIL = 8'h04;
  localparam logic [7:0] MS_HW_RESET = 8'h00;
  localparam logic [7:0] MS_WDOG_RESET = 8'h01;
  localparam logic [7:0] MS_JOINED = 8'h02;
  localparam logic [7:0] MS_DISASSOC = 8'h03;
  localparam logic [7:0] MS_COORD_START = 8'h06;
  localparam logic [7:0] MS_KEY_UPDATE = 8'h07;
  localparam logic [7:0] MS_SUPPLY_LIMIT = 8'h0D;
  localparam logic [7:0] MS_CFG_IN_JOIN = 8'h11;
  localparam logic [7:0] MS_STACK_ERR = 8'h80;

  // ************************************************************************
  // Register map, interrupt bits and bus response codes
  // ************************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_MODEM_SEND = 8'h0C;
  localparam logic [7:0] REG_FRAME_COUNT = 8'h10;
  localparam int IRQ_W = 3;
  localparam int IRQ_FRAME_DONE = 0;
  localparam int IRQ_SUPPRESSED = 1;
  localparam int IRQ_MODEM_OVERRUN = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : afb_pkg

// File: rtl/afb_frame_builder.sv
/*
 * Serial API frame builder: emits command response frames and unsolicited
 * modem status frames as a byte stream with valid/ready, plus an AXI4-Lite
 * control port with a read-to-clear interrupt status. Assumes one clock and
 * a host that may stall the stream at any byte.
 */
`timescale 1ns/1ns
`default_nettype none
module afb_frame_builder #(
  parameter int DATA_BYTES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_frame_id,
  input wire logic [7:0] cmd_char0,
  input wire logic [7:0] cmd_char1,
  input wire logic [7:0] cmd_status,
  input wire logic [8*DATA_BYTES-1:0] cmd_data,
  input wire logic [3:0] cmd_data_len,
  input wire logic modem_evt_valid,
  input wire logic [7:0] modem_evt_code,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic irq
);

  // ************************************************************************
  // State
  // ************************************************************************
  localparam int DW = 8 * DATA_BYTES;
  localparam logic [3:0] MAX_LEN = 4'(DATA_BYTES);

  typedef enum logic [0:0] {
    AFB_IDLE = 1'b0,
    AFB_SEND = 1'b1
  } afb_state_t;

  typedef struct packed {
    afb_state_t st;
    logic modem;
    logic [7:0] fid;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] code;
    logic [DW-1:0] data;
    logic [3:0] dlen;
    logic [4:0] idx;
    logic [7:0] sum;
    logic [7:0] tx_data;
    logic tx_valid;
    logic cmd_ready;
    logic modem_pend;
    logic [7:0] modem_code;
    logic enable;
    logic [afb_pkg::IRQ_W-1:0] irq_st;
    logic [afb_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic [15:0] frame_cnt;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy, w_rdy, ar_rdy;
  } afb_regs_t;

  afb_regs_t s_q;
  afb_regs_t s_d;

  // Frame length field and index of the checksum byte for the frame in flight.
  logic [7:0] len;
  logic [4:0] last;
  assign len = s_q.modem ? afb_pkg::MODEM_LEN
                         : 8'(afb_pkg::RESP_BASE_LEN + 8'(s_q.dlen));
  assign last = 5'(afb_pkg::OFF_TYPE + len[4:0]);

  // ************************************************************************
  // Next-state logic
  // ************************************************************************
  // Bus slave, event capture, frame sequencing and interrupts in one pass.
  always_comb begin
    logic [afb_pkg::IRQ_W-1:0] irq_set;
    logic [afb_pkg::IRQ_W-1:0] irq_clr;
    logic [7:0] sum_new;
    logic [4:0] n;
    logic [3:0] dl;
    logic [7:0] ra;
    logic mnew;
    irq_set = '0;
    irq_clr = '0;
    sum_new = s_q.sum;
    n = s_q.idx;
    dl = '0;
    ra = '0;
    mnew = 1'b0;
    s_d = s_q;

    // Write address and data are taken separately, in either order.
    if (s_axi_awvalid && !s_q.aw_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have && !s_q.bvalid) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Modem events from the stack; a second event before the first is sent
    // replaces it and is flagged as an overrun.
    if (modem_evt_valid) begin
      if (s_q.modem_pend) begin
        irq_set[afb_pkg::IRQ_MODEM_OVERRUN] = 1'b1;
      end
      s_d.modem_pend = 1'b1;
      s_d.modem_code = modem_evt_code;
      mnew = 1'b1;
    end

    // Register write once both halves are held.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = afb_pkg::RESP_OKAY;
      unique case (s_q.aw_addr[7:2])
        afb_pkg::REG_CTRL[7:2]: begin
          if (s_q.wstrb0) s_d.enable = s_q.wdata[0];
        end
        afb_pkg::REG_IRQ_MASK[7:2]: begin
          if (s_q.wstrb0) s_d.irq_mask = s_q.wdata[afb_pkg::IRQ_W-1:0];
        end
        afb_pkg::REG_MODEM_SEND[7:2]: begin
          if (s_q.wstrb0 && !modem_evt_valid) begin
            s_d.modem_pend = 1'b1;
            s_d.modem_code = s_q.wdata[7:0];
            mnew = 1'b1;
          end
        end
        afb_pkg::REG_IRQ_STATUS[7:2], afb_pkg::REG_FRAME_COUNT[7:2]: begin
        end
        default: begin
          s_d.bresp = afb_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Register read; reading the status register clears what it returns.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      ra = s_axi_araddr;
      s_d.rvalid = 1'b1;
      s_d.rresp = afb_pkg::RESP_OKAY;
      s_d.rdata = '0;
      unique case (ra[7:2])
        afb_pkg::REG_CTRL[7:2]: s_d.rdata[0] = s_q.enable;
        afb_pkg::REG_IRQ_STATUS[7:2]: begin
          s_d.rdata[afb_pkg::IRQ_W-1:0] = s_q.irq_st;
          irq_clr = s_q.irq_st;
        end
        afb_pkg::REG_IRQ_MASK[7:2]: s_d.rdata[afb_pkg::IRQ_W-1:0] = s_q.irq_mask;
        afb_pkg::REG_MODEM_SEND[7:2]: s_d.rdata[8:0] = {s_q.modem_pend, s_q.modem_code};
        afb_pkg::REG_FRAME_COUNT[7:2]: s_d.rdata[15:0] = s_q.frame_cnt;
        default: s_d.rresp = afb_pkg::RESP_SLVERR;
      endcase
    end

    // Frame sequencer.
    unique case (s_q.st)
      AFB_IDLE: begin
        if (s_q.modem_pend && s_q.enable) begin
          s_d.modem = 1'b1;
          s_d.code = s_q.modem_code;
          s_d.dlen = '0;
          s_d.modem_pend = mnew; // A code that lands as this frame starts stays pending.
          s_d.st = AFB_SEND;
        end else if (cmd_valid && s_q.cmd_ready) begin
          if (cmd_frame_id == afb_pkg::NO_ID) begin
            irq_set[afb_pkg::IRQ_SUPPRESSED] = 1'b1;
          end else begin
            // Every accepted request with a nonzero identifier is answered on its own, so a discovery
            // command may feed several responses with one identifier.
            dl = (cmd_data_len > MAX_LEN) ? MAX_LEN : cmd_data_len;
            s_d.modem = 1'b0;
            s_d.fid = cmd_frame_id;
            s_d.c0 = cmd_char0;
            s_d.c1 = cmd_char1;
            s_d.code = cmd_status;
            s_d.dlen = dl;
            s_d.data = DW'(cmd_data << (DW - 8 * int'(dl)));
            s_d.st = AFB_SEND;
          end
        end
        if (s_d.st == AFB_SEND) begin
          s_d.idx = '0;
          s_d.sum = '0;
          s_d.tx_data = afb_pkg::DELIM;
          s_d.tx_valid = 1'b1;
        end
      end
      AFB_SEND: begin
        if (s_q.tx_valid && tx_ready) begin
          if (s_q.idx >= afb_pkg::OFF_TYPE) begin
            sum_new = 8'(s_q.sum + s_q.tx_data);
          end
          s_d.sum = sum_new;
          if (s_q.idx == last) begin
            s_d.tx_valid = 1'b0;
            s_d.st = AFB_IDLE;
            s_d.frame_cnt = 16'(s_q.frame_cnt + 16'h0001);
            irq_set[afb_pkg::IRQ_FRAME_DONE] = 1'b1;
          end else begin
            n = 5'(s_q.idx + 5'h01);
            s_d.idx = n;
            if (n == last) begin
              s_d.tx_data = 8'(afb_pkg::CSUM_BASE - sum_new);
            end else if (n == afb_pkg::OFF_LEN_HI) begin
              s_d.tx_data = 8'h00;
            end else if (n == afb_pkg::OFF_LEN_LO) begin
              s_d.tx_data = len;
            end else if (n == afb_pkg::OFF_TYPE) begin
              s_d.tx_data = s_q.modem ? afb_pkg::TYPE_MODEM : afb_pkg::TYPE_RESP;
            end else if (n == afb_pkg::OFF_ID) begin
              s_d.tx_data = s_q.modem ? s_q.code : s_q.fid;
            end else if (n == afb_pkg::OFF_CHAR0) begin
              s_d.tx_data = s_q.c0;
            end else if (n == afb_pkg::OFF_CHAR1) begin
              s_d.tx_data = s_q.c1;
            end else if (n == afb_pkg::OFF_STATUS) begin
              s_d.tx_data = s_q.code;
            end else begin
              s_d.tx_data = s_q.data[DW-1 -: 8];
              s_d.data = {s_q.data[DW-9:0], 8'h00};
            end
          end
        end
      end
    endcase

    // Sticky status: a new event wins over a clear in the same cycle.
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_set;
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
    s_d.cmd_ready = (s_d.st == AFB_IDLE) && s_d.enable && !s_d.modem_pend;
    // Bus readies are registered so that every output comes from a flop.
    s_d.aw_rdy = !s_d.aw_have && !s_d.bvalid;
    s_d.w_rdy = !s_d.w_have && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
  end

  // ************************************************************************
  // State register
  // ************************************************************************
  // All state updates here; reset leaves the block idle and disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign cmd_ready = s_q.cmd_ready;
  assign tx_data = s_q.tx_data;
  assign tx_valid = s_q.tx_valid;
  assign irq = s_q.irq;

  // ************************************************************************
  // Assertions
  // ************************************************************************
  a_first_delim: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_valid) |-> tx_data == afb_pkg::DELIM && s_q.idx == 5'h00)
    else $error("Frame did not open with the delimiter.");

  a_length_field: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && s_q.idx == afb_pkg::OFF_LEN_LO |->
      tx_data == (s_q.modem ? 8'h02 : 8'(8'h05 + 8'(s_q.dlen))))
    else $error("Length byte does not match the frame contents.");

  a_checksum_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && s_q.idx == last |-> 8'(s_q.sum + tx_data) == 8'hFF)
    else $error("Checksum byte does not complete the sum to 0xFF.");

  a_frame_type: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && s_q.idx == afb_pkg::OFF_TYPE |->
      tx_data == (s_q.modem ? 8'h8A : 8'h88))
    else $error("Wrong frame type byte.");

  a_id_echo: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_valid && cmd_ready && cmd_frame_id != 8'h00 |=>
      tx_valid && s_q.fid == $past(cmd_frame_id))
    else $error("Response did not keep the frame identifier.");

  a_id_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && !s_q.modem && s_q.idx == afb_pkg::OFF_ID |-> tx_data == s_q.fid)
    else $error("Identifier byte differs from the request.");

  a_zero_id_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_valid && cmd_ready && cmd_frame_id == 8'h00 |=> !tx_valid && s_q.st == AFB_IDLE)
    else $error("A zero identifier request produced a frame.");

  a_name_chars: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && tx_ready && !s_q.modem && s_q.idx == afb_pkg::OFF_CHAR0 |=>
      tx_data == s_q.c1 && $past(tx_data) == s_q.c0)
    else $error("Command name characters out of place.");

  a_modem_len: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && s_q.modem && s_q.idx > afb_pkg::OFF_TYPE |-> s_q.idx <= 5'h05)
    else $error("Modem status frame ran past its checksum.");

  a_stall_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Byte changed while the host stalled.");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(s_q.irq_st & s_q.irq_mask))
    else $error("Interrupt output disagrees with status and mask.");

endmodule : afb_frame_builder
`default_nettype wire

// File: dv/afb_host_model.sv
/*
 * Host parser model: takes the frame byte stream, stalls it at random when
 * told to be slow, keeps every byte and counts frames with a bad checksum.
 * Assumes one clock shared with the frame builder.
 */
`timescale 1ns/1ns
`default_nettype none
module afb_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] rx[$];
  logic [7:0] sum = 8'h00;
  logic slow = 1'b0;
  int idx = 0;
  int len = 0;
  int bad = 0;
  int sd = 76244;

  // ************************************************************************
  // Byte capture and frame check
  // ************************************************************************
  // Accepts any identifier and any status code, repeated or unknown alike.
  always @(posedge aclk) begin
    tx_ready <= aresetn && (!slow || ($random(sd) & 3) == 0);
    if (aresetn && tx_valid && tx_ready) begin
      rx.push_back(tx_data);
      if (idx == 2) len = tx_data;
      if (idx >= 3) sum = sum + tx_data;
      idx++;
      if (idx > 3 && idx == len + 4) begin
        if (sum != 8'hff) bad++;
        idx = 0;
        sum = 8'h00;
      end
    end
  end
endmodule : afb_host_model
`default_nettype wire

// File: dv/tb_top.sv
/*
 * Self-checking bench for the frame builder: AXI4-Lite register access,
 * command requests, modem events and a host model on the byte stream.
 * Assumes the design and host model files are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int NB = 8;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmd_valid, cmd_ready;
  logic modem_evt_valid, tx_valid, tx_ready, irq;
  logic [7:0] awaddr, araddr, cmd_frame_id, cmd_char0, cmd_char1, cmd_status;
  logic [7:0] modem_evt_code, tx_data;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cmd_data_len;
  logic [1:0] bresp, rresp;
  logic [8*NB-1:0] cmd_data;
  logic [7:0] ex[$];
  int num_errors = 0;
  int comparisons = 0;
  int sd = 76244;

  afb_frame_builder #(.DATA_BYTES(NB)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_frame_id(cmd_frame_id), .cmd_char0(cmd_char0),
    .cmd_char1(cmd_char1), .cmd_status(cmd_status), .cmd_data(cmd_data),
    .cmd_data_len(cmd_data_len), .modem_evt_valid(modem_evt_valid),
    .modem_evt_code(modem_evt_code), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .irq(irq));

  afb_host_model host (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  // Clock of 20 ns period.
  always #10 aclk = ~aclk;

  // ************************************************************************
  // Checking and verdict
  // ************************************************************************
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Appends a whole expected frame: delimiter, length, type, body, checksum.
  function automatic void put_frame(input logic [7:0] ty, input logic [7:0] b[$]);
    logic [7:0] s;
    s = ty;
    foreach (b[i]) s = s + b[i];
    ex.push_back(8'h7e);
    ex.push_back(8'h00);
    ex.push_back(8'(b.size() + 1));
    ex.push_back(ty);
    foreach (b[i]) ex.push_back(b[i]);
    ex.push_back(8'hff - s);
  endfunction : put_frame

  // Waits for the expected bytes, lets stray ones show, then compares all.
  task automatic drain;
    while (host.rx.size() < ex.size()) @(posedge aclk);
    repeat (30) @(posedge aclk);
    chk(32'(host.rx.size()), 32'(ex.size()));
    while (ex.size() > 0) chk(32'(host.rx.pop_front()), 32'(ex.pop_front()));
    host.rx.delete();
  endtask : drain

  // ************************************************************************
  // Bus and request drivers
  // ************************************************************************
  // One AXI4-Lite write; the closing edge keeps strobes apart between calls.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask : axw

  // One AXI4-Lite read, compared with the expected word and response.
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask : axr

  // Offers one command request until taken and records its expected reply when the identifier is nonzero.
  task automatic send_cmd(input logic [7:0] id, input logic [7:0] st, input int n);
    logic [7:0] b[$];
    logic [7:0] c0;
    logic [7:0] c1;
    logic [63:0] d;
    c0 = 8'($random(sd));
    c1 = 8'($random(sd));
    d = {$random(sd), $random(sd)};
    cmd_frame_id <= id;
    cmd_char0 <= c0;
    cmd_char1 <= c1;
    cmd_status <= st;
    cmd_data <= d;
    cmd_data_len <= 4'(n);
    cmd_valid <= 1'b1;
    do @(posedge aclk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    if (id != 8'h00) begin
      b = {id, c0, c1, st};
      for (int k = n - 1; k >= 0; k--) b.push_back(d[8*k +: 8]);
      put_frame(8'h88, b);
    end
    @(posedge aclk);
  endtask : send_cmd

  // Pulses one modem event for a single cycle.
  task automatic modem(input logic [7:0] c);
    modem_evt_code <= c;
    modem_evt_valid <= 1'b1;
    @(posedge aclk);
    modem_evt_valid <= 1'b0;
    @(posedge aclk);
  endtask : modem

  // ************************************************************************
  // Test sequence
  // ************************************************************************
  // Reset, registers, commands, modem events, ordering and overrun.
  initial begin
    logic [7:0] codes[$];
    codes = {8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0d, 8'h11, 8'h80, 8'hf5};
    {awvalid, wvalid, bready, arvalid, rready, cmd_valid, modem_evt_valid} = '0;
    {awaddr, araddr, wdata, cmd_frame_id, cmd_char0, cmd_char1} = '0;
    {cmd_status, cmd_data, cmd_data_len, modem_evt_code} = '0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({tx_valid, cmd_ready, irq}), 32'h0000_0000);
    axr(8'h20, 32'h0000_0000, 2'b10);
    axw(8'h20, 32'h0000_0001, 2'b10);
    axw(8'h00, 32'h0000_0001, 2'b00);
    wstrb <= 4'h0;
    axw(8'h00, 32'h0000_0000, 2'b00);
    wstrb <= 4'hf;
    axr(8'h00, 32'h0000_0001, 2'b00);
    axw(8'h08, 32'h0000_0007, 2'b00);
    axr(8'h08, 32'h0000_0007, 2'b00);
    // Random requests: empty and full data, a zero and a repeated identifier.
    for (int i = 0; i < 12; i++) begin
      host.slow = i[0];
      send_cmd((i == 3) ? 8'h00 : (i == 4 || i == 5) ? 8'h42 : 8'($random(sd)) | 8'h01,
               8'(i % 5), (i == 0) ? 0 : (i == 1) ? NB : ($random(sd) & 15) % 9);
    end
    drain;
    axr(8'h10, 32'h0000_000b, 2'b00);
    chk(32'(irq), 32'h0000_0001);
    axr(8'h04, 32'h0000_0003, 2'b00);
    axr(8'h04, 32'h0000_0000, 2'b00);
    // Every listed modem code and one unknown, with interrupts masked.
    axw(8'h08, 32'h0000_0000, 2'b00);
    foreach (codes[i]) begin
      modem(codes[i]);
      put_frame(8'h8a, {codes[i]});
      drain;
    end
    chk(32'(irq), 32'h0000_0000);
    axr(8'h04, 32'h0000_0001, 2'b00);
    axw(8'h08, 32'h0000_0007, 2'b00);
    // An event during a response goes out before the next waiting request.
    host.slow = 1'b1;
    send_cmd(8'h11, 8'h00, 2);
    modem(8'h06);
    put_frame(8'h8a, {8'h06});
    send_cmd(8'h12, 8'h01, 0);
    drain;
    axr(8'h04, 32'h0000_0001, 2'b00);
    // Two events while disabled: the second replaces the first.
    axw(8'h00, 32'h0000_0000, 2'b00);
    chk(32'(cmd_ready), 32'h0000_0000);
    modem(8'h02);
    modem(8'h03);
    axr(8'h0c, 32'h0000_0103, 2'b00);
    chk(32'(irq), 32'h0000_0001);
    axr(8'h04, 32'h0000_0004, 2'b00);
    axw(8'h00, 32'h0000_0001, 2'b00);
    put_frame(8'h8a, {8'h03});
    drain;
    axw(8'h0c, 32'h0000_0011, 2'b00);
    put_frame(8'h8a, {8'h11});
    drain;
    chk(32'(host.bad), 32'h0000_0000);
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (50000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
